// ---- verilog/dbg_mode_consts.vh ----
`ifndef DBG_MODE_CONSTS_VH
`define DBG_MODE_CONSTS_VH
`define ADDR_PIN_DIGITAL_ENABLE   8'h00
`define ADDR_PIN_PULL_UP_SELECT   8'h04
`define ADDR_PIN_ALT_FUNC_SELECT  8'h08
`define ADDR_PIN_CONFIG_LOCK      8'h0C
`define ADDR_PIN_COMMIT_MASK      8'h10
`define ADDR_DEBUG_STATUS         8'h14
`define PIN_COUNT                 5
`define PIN_RESET_VALUE           5'h1F
`define COMMIT_RESET_VALUE        5'h00
`define LOCK_KEY                  32'h4C4F434B
`define CODE_JTAG_TO_SWD          16'hE79E
`define CODE_SWD_TO_JTAG          16'hE73C
`define ONES_RUN_MIN              7'h32
`define TLR_ONES_COUNT            3'h5
`define RECOVERY_COUNT            4'hA
`define STATUS_SWD_BIT            0
`define STATUS_ERASE_BIT          1
`define STATUS_LOCKED_BIT         2
`define STATUS_TLR_BIT            3
`endif

// ---- verilog/debug_port_mode_switch.v ----
// Functional notes
// - Reset gives five pins full debug function
// - Zero alternate select bits hand pins to GPIO
// - Protected writes need unlock and commit mask
// - Ten switches under held reset mass-erase flash
// - Trailing ones run optional during recovery
// - Recognise triple TAP preamble walk from reset
// - Completed preamble selects serial-wire, disables JTAG
// - JTAG-to-SWD code E79E, LSB first
// - SWD-to-JTAG code E73C, LSB first
// - GPIO pins need select bits restored for JTAG
// - Five ones on mode line reach Test-Logic-Reset
// - Sample mode and data on rising test clock
`timescale 1ns/1ps
`include "dbg_mode_consts.vh"

module debug_port_mode_switch (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        test_clock,
    input  wire        mode_data,
    input  wire        sys_reset_held,
    output wire [4:0]  pin_digital_enable,
    output wire [4:0]  pin_pull_up_select,
    output wire [4:0]  pin_alternate_function_select,
    output reg         swd_selected,
    output reg         tap_in_reset,
    output reg         mass_erase_pulse
);

localparam TAP_RESET     = 4'h0;
localparam TAP_IDLE      = 4'h1;
localparam TAP_SEL_DR    = 4'h2;
localparam TAP_SEL_IR    = 4'h3;
localparam TAP_OTHER     = 4'h4;

reg  [4:0]  den_reg;
reg  [4:0]  pur_reg;
reg  [4:0]  afsel_reg;
reg  [4:0]  commit_reg;
reg         unlocked_reg;
reg         erase_done_reg;
reg         ap_valid_reg;
reg         ap_write_reg;
reg  [7:0]  ap_addr_reg;
reg  [1:0]  tck_sync_reg;
reg  [1:0]  tms_sync_reg;
reg         tck_prev_reg;
reg  [15:0] shift_reg;
reg  [6:0]  ones_reg;
reg         armed_reg;
reg  [4:0]  code_count_reg;
reg  [2:0]  tlr_count_reg;
reg  [3:0]  tap_reg;
reg  [3:0]  walk_reg;
reg  [3:0]  recover_reg;
reg         expect_swd_reg;
reg  [15:0] shift_next;
reg  [3:0]  tap_next;
reg  [3:0]  walk_next;
reg  [3:0]  walk_want;
reg  [4:0]  den_next;
reg  [4:0]  pur_next;
reg  [4:0]  afsel_next;
reg  [4:0]  commit_next;
reg         unlocked_next;
wire        tck_rise;
wire        tms_s;
wire        take;
wire        wr_en;
wire [4:0]  afsel_wmask;
wire        hit_to_swd;
wire        hit_to_jtag;
wire        code_done;

assign hreadyout = 1'b1;
assign hresp     = 1'b0;
assign take      = hsel & hready & htrans[1];
assign wr_en     = ap_valid_reg & ap_write_reg;

// Every write to the selects is gated, so a stray store cannot drop the select bits; digital enable and pull-up writes are not gated
assign afsel_wmask = unlocked_reg ? commit_reg : 5'h00;

assign pin_digital_enable            = den_reg;
assign pin_pull_up_select            = pur_reg;
assign pin_alternate_function_select = afsel_reg;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ap_valid_reg <= 1'b0;
        ap_write_reg <= 1'b0;
        ap_addr_reg  <= 8'h00;
    end else begin
        ap_valid_reg <= take;
        ap_write_reg <= hwrite;
        ap_addr_reg  <= haddr[7:0];
    end
end

// Next values of the pin registers; the read path samples these as well
always @* begin
    den_next      = den_reg;
    pur_next      = pur_reg;
    afsel_next    = afsel_reg;
    commit_next   = commit_reg;
    unlocked_next = unlocked_reg;
    if (wr_en) begin
        case (ap_addr_reg)
            `ADDR_PIN_DIGITAL_ENABLE: begin
                den_next = hwdata[4:0];
            end
            `ADDR_PIN_PULL_UP_SELECT: begin
                pur_next = hwdata[4:0];
            end
            `ADDR_PIN_ALT_FUNC_SELECT: begin
                afsel_next = (afsel_reg & ~afsel_wmask) | (hwdata[4:0] & afsel_wmask);
            end
            `ADDR_PIN_CONFIG_LOCK: begin
                unlocked_next = (hwdata == `LOCK_KEY);
            end
            `ADDR_PIN_COMMIT_MASK: begin
                if (unlocked_reg) begin
                    commit_next = hwdata[4:0];
                end
            end
            default: begin
            end
        endcase
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        den_reg      <= `PIN_RESET_VALUE;
        pur_reg      <= `PIN_RESET_VALUE;
        afsel_reg    <= `PIN_RESET_VALUE;
        commit_reg   <= `COMMIT_RESET_VALUE;
        unlocked_reg <= 1'b0;
    end else begin
        den_reg      <= den_next;
        pur_reg      <= pur_next;
        afsel_reg    <= afsel_next;
        commit_reg   <= commit_next;
        unlocked_reg <= unlocked_next;
    end
end

// Read data is taken in the address phase from next values, so a write that
// finishes at the same edge is already seen and the word stands all data phase
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
        case (haddr[7:0])
            `ADDR_PIN_DIGITAL_ENABLE:  hrdata <= {27'h0000000, den_next};
            `ADDR_PIN_PULL_UP_SELECT:  hrdata <= {27'h0000000, pur_next};
            `ADDR_PIN_ALT_FUNC_SELECT: hrdata <= {27'h0000000, afsel_next};
            `ADDR_PIN_CONFIG_LOCK:     hrdata <= {31'h00000000, ~unlocked_next};
            `ADDR_PIN_COMMIT_MASK:     hrdata <= {27'h0000000, commit_next};
            `ADDR_DEBUG_STATUS:        hrdata <= {28'h0000000, tap_in_reset, ~unlocked_next,
                                                  erase_done_reg, swd_selected};
            default:                   hrdata <= 32'h00000000;
        endcase
    end else begin
        hrdata <= 32'h00000000;
    end
end

// Test clock and mode line are foreign; two flops each before any use
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        // Test clock idles high on its pull-up; matching it avoids a false edge
        tck_sync_reg <= 2'b11;
        tms_sync_reg <= 2'b11;
        tck_prev_reg <= 1'b1;
    end else begin
        tck_sync_reg <= {tck_sync_reg[0], test_clock};
        tms_sync_reg <= {tms_sync_reg[0], mode_data};
        tck_prev_reg <= tck_sync_reg[1];
    end
end

// Mode is sampled at the rising edge; the debugger moves it on the falling one
assign tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
assign tms_s    = tms_sync_reg[1];

always @* begin
    shift_next = {tms_s, shift_reg[15:1]};
end

assign code_done   = armed_reg && (code_count_reg == 5'h0F);
assign hit_to_swd  = code_done && (shift_next == `CODE_JTAG_TO_SWD);
assign hit_to_jtag = code_done && (shift_next == `CODE_SWD_TO_JTAG);

// TAP walk tracking, reduced to the states the preamble visits
always @* begin
    case (tap_reg)
        TAP_RESET:  tap_next = tms_s ? TAP_RESET : TAP_IDLE;
        TAP_IDLE:   tap_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: tap_next = tms_s ? TAP_SEL_IR : TAP_OTHER;
        TAP_SEL_IR: tap_next = tms_s ? TAP_RESET : TAP_OTHER;
        default:    tap_next = TAP_OTHER;
    endcase
    if (tms_s && (tlr_count_reg == `TLR_ONES_COUNT - 3'h1)) begin
        tap_next = TAP_RESET;
    end
end

// Preamble: the state the TAP must enter next, given the steps matched so far
always @* begin
    case (walk_reg)
        4'h0:    walk_want = TAP_IDLE;
        4'h1:    walk_want = TAP_SEL_DR;
        4'h2:    walk_want = TAP_SEL_IR;
        4'h3:    walk_want = TAP_RESET;
        4'h4:    walk_want = TAP_RESET;
        4'h5:    walk_want = TAP_IDLE;
        4'h6:    walk_want = TAP_IDLE;
        4'h7:    walk_want = TAP_SEL_DR;
        4'h8:    walk_want = TAP_SEL_IR;
        4'h9:    walk_want = TAP_RESET;
        4'hA:    walk_want = TAP_RESET;
        4'hB:    walk_want = TAP_IDLE;
        4'hC:    walk_want = TAP_IDLE;
        4'hD:    walk_want = TAP_SEL_DR;
        4'hE:    walk_want = TAP_SEL_IR;
        default: walk_want = TAP_RESET;
    endcase
end

// A broken walk restarts; leaving reset for idle is itself a first step
always @* begin
    if (walk_reg == 4'hF) begin
        walk_next = 4'h0;
    end else if (tap_next == walk_want && (walk_reg != 4'h0 || tap_reg == TAP_RESET)) begin
        walk_next = walk_reg + 4'h1;
    end else if (tap_reg == TAP_RESET && tap_next == TAP_IDLE) begin
        walk_next = 4'h1;
    end else begin
        walk_next = 4'h0;
    end
end

// Shift register and tracked TAP state advance on every sampled rise
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        shift_reg    <= 16'hFFFF;
        tap_reg      <= TAP_RESET;
        tap_in_reset <= 1'b1;
    end else if (tck_rise) begin
        shift_reg    <= shift_next;
        tap_reg      <= tap_next;
        tap_in_reset <= (tap_next == TAP_RESET);
    end
end

// Runs of ones: a long run arms the code window, five reach reset
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ones_reg      <= 7'h00;
        tlr_count_reg <= 3'h0;
    end else if (tck_rise) begin
        if (tms_s) begin
            ones_reg      <= (ones_reg == `ONES_RUN_MIN) ? ones_reg : ones_reg + 7'h01;
            tlr_count_reg <= (tlr_count_reg == `TLR_ONES_COUNT) ? tlr_count_reg
                                                                : tlr_count_reg + 3'h1;
        end else begin
            ones_reg      <= 7'h00;
            tlr_count_reg <= 3'h0;
        end
    end
end

// Code window opens with the first zero after a long run of ones
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        armed_reg      <= 1'b0;
        code_count_reg <= 5'h00;
    end else if (tck_rise) begin
        if (!tms_s && ones_reg == `ONES_RUN_MIN) begin
            armed_reg      <= 1'b1;
            code_count_reg <= 5'h01;
        end else if (armed_reg) begin
            code_count_reg <= code_count_reg + 5'h01;
            if (code_done) begin
                armed_reg <= 1'b0;
            end
        end
    end
end

// Mode follows the last valid switch; the preamble only lifts JTAG to serial-wire
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        walk_reg     <= 4'h0;
        swd_selected <= 1'b0;
    end else if (tck_rise) begin
        walk_reg <= walk_next;
        if (hit_to_swd) begin
            swd_selected <= 1'b1;
        end else if (hit_to_jtag) begin
            swd_selected <= 1'b0;
        end else if (!swd_selected && walk_reg == 4'hF && tap_next == TAP_RESET) begin
            swd_selected <= 1'b1;
        end
    end
end

// Recovery count restarts whenever system reset is let go early or order breaks
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        recover_reg      <= 4'h0;
        expect_swd_reg   <= 1'b1;
        erase_done_reg   <= 1'b0;
        mass_erase_pulse <= 1'b0;
    end else begin
        mass_erase_pulse <= 1'b0;
        if (!sys_reset_held) begin
            recover_reg    <= 4'h0;
            expect_swd_reg <= 1'b1;
        end else if (tck_rise && (hit_to_swd || hit_to_jtag)) begin
            // Only the lead-in ones and the code matter, so no trailing run is awaited
            if (hit_to_swd == expect_swd_reg) begin
                expect_swd_reg <= ~expect_swd_reg;
                if (recover_reg == `RECOVERY_COUNT - 4'h1) begin
                    recover_reg      <= 4'h0;
                    mass_erase_pulse <= 1'b1;
                    erase_done_reg   <= 1'b1;
                end else begin
                    recover_reg <= recover_reg + 4'h1;
                end
            end else begin
                recover_reg    <= hit_to_swd ? 4'h1 : 4'h0;
                expect_swd_reg <= ~hit_to_swd;
            end
        end
    end
end

endmodule // debug_port_mode_switch

// ---- test/debug_port_mode_switch_asserts.sv ----
`timescale 1ns/1ps
module debug_port_mode_switch_asserts (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        test_clock,
    input wire logic        mode_data,
    input wire logic        sys_reset_held,
    input wire logic [4:0]  pin_alternate_function_select,
    input wire logic        swd_selected,
    input wire logic        tap_in_reset,
    input wire logic        mass_erase_pulse
);
    logic        tck_q, sel_wr_q;
    logic [2:0]  ones_cnt;
    logic [15:0] last_bits;
    wire  [4:0]  sel = pin_alternate_function_select;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Raw test clock seen here a few cycles before the design's synchroniser reacts
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tck_q     <= 1'h1;
            sel_wr_q  <= 1'h0;
            ones_cnt  <= 3'h0;
            last_bits <= 16'h0;
        end else begin
            tck_q    <= test_clock;
            sel_wr_q <= hsel && htrans[1] && hwrite && haddr == 32'h8;
            if (test_clock && !tck_q) begin
                last_bits <= {mode_data, last_bits[15:1]};
                ones_cnt  <= mode_data ? ones_cnt + {2'h0, ones_cnt != 3'h7} : 3'h0;
            end
        end
    end
    a_reset_select_set: assert property (
        $rose(hresetn) |-> sel == 5'h1F) else $error("Select bits not set after reset");
    a_select_write_only: assert property (
        !$stable(sel) |-> $past(sel_wr_q)) else $error("Select bits changed without a write");
    a_erase_single: assert property (
        mass_erase_pulse |=> !mass_erase_pulse) else $error("Erase pulse too long");
    a_erase_in_reset: assert property (
        mass_erase_pulse |-> sys_reset_held) else $error("Erase outside held reset");
    a_erase_last_code: assert property (
        mass_erase_pulse |-> last_bits == 16'hE73C) else $error("Erase not on tenth code");
    a_ones_tap_reset: assert property (
        $rose(ones_cnt == 3'h5) |-> ##[0:8] tap_in_reset) else $error("Five ones missed reset");
    a_swd_code_seen: assert property (
        $rose(swd_selected) |-> last_bits == 16'hE79E) else $error("Serial mode without code");
    a_jtag_code_seen: assert property (
        $fell(swd_selected) |-> last_bits == 16'hE73C) else $error("Scan mode without code");
endmodule // debug_port_mode_switch_asserts

// ---- test/debug_probe_model.sv ----
`timescale 1ns/1ps
module debug_probe_model (
    output logic test_clock,
    output logic mode_data
);
    // Clock parks high between frames; the line is pulled up when released
    initial begin
        test_clock = 1'h1;
        mode_data  = 1'h1;
    end
    task send_bit(input logic b);
        begin
            test_clock = 1'h0;
            mode_data  = b;
            #62.5;
            test_clock = 1'h1;
            #62.5;
        end
    endtask
    task send(input int lead, input logic [15:0] code, input int trail);
        begin
            repeat (lead) send_bit(1'h1);
            for (int i = 0; i < 16; i++) send_bit(code[i]);
            repeat (trail) send_bit(1'h1);
        end
    endtask
endmodule // debug_probe_model

// ---- test/debug_port_mode_switch_test.sv ----
`timescale 1ns/1ps
module debug_port_mode_switch_test;
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, sys_reset_held = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, seed;
    wire         hreadyout, hresp, test_clock, mode_data, swd_selected, tap_in_reset;
    wire         mass_erase_pulse;
    wire  [31:0] hrdata;
    wire  [4:0]  pin_digital_enable, pin_pull_up_select, pin_alternate_function_select;
    int          num_errors = 0, tests_run = 0, erase_cnt = 0, m_sel = 31, m_mask, m_dat;
    debug_port_mode_switch i_dut (.hready(hreadyout), .*);
    debug_probe_model i_probe (.*);
    always #4 hclk = ~hclk;
    always @(posedge hclk) if (mass_erase_pulse === 1'h1) erase_cnt++;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            tests_run++;
            if (seen !== exp) begin
                num_errors++;
                $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            hsel   <= 1'h1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr  <= {24'h0, a};
            @(posedge hclk);
            while (hreadyout !== 1'h1) @(posedge hclk);
            hsel   <= 1'h0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge hclk);
            while (hreadyout !== 1'h1) @(posedge hclk);
            rd = hrdata;
            check(hresp, 32'h0);
        end
    endtask
    // Settle time covers the synchroniser and edge detector after the last bit
    task link(input int lead, input logic [15:0] code, input int trail, input int m_swd);
        begin
            i_probe.send(lead, code, trail);
            repeat (10) @(posedge hclk);
            check(swd_selected, m_swd);
        end
    endtask
    task stop_test;
        begin
            $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        #500000;
        num_errors++;
        stop_test();
    end
    initial begin
        seed = 32'hC9BB8A11;
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        check(pin_alternate_function_select, 5'h1F);
        check({pin_digital_enable, pin_pull_up_select}, 32'h3FF);
        bus(1'h1, 8'h08, 32'h0);
        bus(1'h0, 8'h08, 32'h0);
        check(rd, m_sel);
        bus(1'h1, 8'h0C, 32'h4C4F434B);
        m_mask = $random(seed) & 31;
        m_dat = $random(seed) & 31;
        m_sel = (m_sel & ~m_mask | m_dat & m_mask) & 31;
        bus(1'h1, 8'h10, m_mask);
        bus(1'h1, 8'h08, m_dat);
        bus(1'h0, 8'h08, 32'h0);
        check(rd, m_sel);
        bus(1'h1, 8'h10, 32'h1F);
        bus(1'h1, 8'h08, 32'h0);
        bus(1'h0, 8'h40, 32'h0);
        check(rd, 32'h0);
        check(pin_alternate_function_select, 5'h0);
        bus(1'h1, 8'h0C, 32'h0);
        bus(1'h1, 8'h08, 32'h1F);
        bus(1'h0, 8'h08, 32'h0);
        check(rd, 32'h0);
        bus(1'h1, 8'h0C, 32'h4C4F434B);
        bus(1'h1, 8'h08, 32'h1F);
        bus(1'h0, 8'h08, 32'h0);
        check(rd, 32'h1F);
        link(50, 16'hE79E, 50, 1);
        link(50, 16'hE73C, 5, 0);
        check(tap_in_reset, 1'h1);
        link(5, 16'hE79E, 0, 1);
        link(10, 16'hE73C, 5, 1);
        link(50, 16'hE73C, 5, 0);
        sys_reset_held <= 1'h1;
        for (int k = 0; k < 10; k++) begin
            check(erase_cnt, 0);
            link(50, k[0] ? 16'hE73C : 16'hE79E, 0, k[0] ? 0 : 1);
        end
        check(erase_cnt, 1);
        bus(1'h0, 8'h14, 32'h0);
        check(rd & 32'h3, 32'h2);
        sys_reset_held <= 1'h0;
        stop_test();
    end
endmodule // debug_port_mode_switch_test
bind debug_port_mode_switch debug_port_mode_switch_asserts i_chk (.*);
